// *** hw/bit_toggle_and_overflow_branch.sv ***
// Notes on behaviour
// (RULE1) Bit toggle inverts only the chosen bit 0..7 and writes the byte back.
// (RULE2) Access bit 0 resolves the file address inside the access bank.
// (RULE3) Access bit 1 takes the bank from the data bank selector.
// (RULE4) Access 0, extended set on, address up to 95: indexed literal offset.
// (RULE5) Upper opcode byte 1110 0100 is the overflow branch; low byte is offset.
// (RULE6) Branch taken only when overflow flag is 1, else fall through.
// (RULE7) Taken target is incremented fetch address plus twice the offset.
// (RULE8) Offset is signed -128..127 words, sign-extended before doubling.
// (RULE9) Taken branch adds a second cycle run as a no-operation.
// (RULE10) Branch is one word, one cycle untaken and two cycles taken.
// (RULE11) No status flag changes; toggle reads Q2, processes Q3, writes Q4.
// (RULE12) Untaken branch does no program counter write in Q4.
`timescale 1ns/1ns
module bit_toggle_and_overflow_branch
	import bto_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                rst_n_i,
	input  wire logic [INSTR_W-1:0]  instr_i,
	input  wire logic                instr_valid_i,
	input  wire logic                overflow_flag_i,
	input  wire logic [BANK_W-1:0]   data_bank_selector_i,
	input  wire logic                ext_set_en_i,
	input  wire logic [ADDR_W-1:0]   index_base_i,
	input  wire logic [PC_W-1:0]     fetch_pc_i,
	input  wire logic [DATA_W-1:0]   mem_rdata_i,
	output logic      [ADDR_W-1:0]   mem_addr_o,
	output logic                     mem_rd_o,
	output logic                     mem_wr_o,
	output logic      [DATA_W-1:0]   mem_wdata_o,
	output logic                     pc_load_o,
	output logic      [PC_W-1:0]     program_counter_o,
	output logic                     nop_cycle_o,
	output logic                     status_we_o,
	output logic      [PHASE_W-1:0]  phase_o
);

	phase_if ph ();

	phase_sequencer u_phase (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ph        (ph)
	);

	// Resolve an 8-bit file address to a 12-bit data memory address
	function automatic logic [ADDR_W-1:0] resolve_addr(
		input logic [7:0]        f,
		input logic              access_sel,
		input logic [BANK_W-1:0] bank,
		input logic              ext_en,
		input logic [ADDR_W-1:0] base
	);
		logic [ADDR_W-1:0] addr;
		addr = {bank, f};
		if (!access_sel) begin
			// (RULE4) indexed literal offset
			if (ext_en && (f <= INDEXED_LIMIT)) begin
				addr = ADDR_W'(base + {4'h0, f});
			// (RULE2) access bank split
			end else if (f < ACCESS_SPLIT) begin
				addr = {ACCESS_LOW_BANK, f};
			end else begin
				addr = {ACCESS_HIGH_BANK, f};
			end
		end else begin
			// (RULE3) banked via selector
			addr = {bank, f};
		end
		return addr;
	endfunction : resolve_addr

	// Word offset to byte displacement at program counter width
	function automatic logic [PC_W-1:0] word_disp(input logic [7:0] n);
		logic [PC_W-1:0] disp;
		// (RULE8) sign-extend then double
		disp = {{(PC_W-9){n[7]}}, n, 1'b0};
		return disp;
	endfunction : word_disp

	op_t               op;
	op_t               next_op;
	logic [7:0]        operand;
	logic [7:0]        next_operand;
	logic [2:0]        bit_sel;
	logic [2:0]        next_bit_sel;
	logic [DATA_W-1:0] data_byte;
	logic [DATA_W-1:0] next_data_byte;
	logic              taken;
	logic              next_taken;
	logic [ADDR_W-1:0] next_mem_addr;
	logic              next_mem_rd;
	logic              next_mem_wr;
	logic [DATA_W-1:0] next_mem_wdata;
	logic              next_pc_load;
	logic [PC_W-1:0]   next_pc;
	logic              next_nop_cycle;
	logic [PHASE_W-1:0] next_phase_o;

	// Per-phase execution of the captured instruction
	always_comb begin
		next_op        = op;
		next_operand   = operand;
		next_bit_sel   = bit_sel;
		next_data_byte = data_byte;
		next_taken     = taken;
		next_mem_addr  = mem_addr_o;
		next_mem_rd    = 1'b0;
		next_mem_wr    = 1'b0;
		next_mem_wdata = mem_wdata_o;
		next_pc_load   = 1'b0;
		next_pc        = program_counter_o;
		next_nop_cycle = nop_cycle_o;
		// Phase of the coming clock, so phase_o lines up with the registered strobes
		next_phase_o   = ph.phase + 2'h1;
		case (ph.phase)
			PHASE_Q1: begin
				next_op    = OP_NONE;
				next_taken = 1'b0;
				if (nop_cycle_o) begin
					// (RULE9) second cycle ignored
					next_op = OP_FLUSH;
				end else if (instr_valid_i) begin
					next_operand = instr_i[OPERAND_MSB:0];
					next_bit_sel = instr_i[TOGGLE_BIT_MSB:TOGGLE_BIT_LSB];
					// (RULE5) branch opcode match
					if (instr_i[15:8] == OPC_BRANCH_HI) begin
						next_op = OP_BRANCH;
					end else if (instr_i[15:12] == OPC_TOGGLE_HI) begin
						next_op       = OP_TOGGLE;
						next_mem_addr = resolve_addr(instr_i[OPERAND_MSB:0],
							instr_i[ACCESS_SEL_POS], data_bank_selector_i,
							ext_set_en_i, index_base_i);
						// (RULE11) read strobe in Q2
						next_mem_rd   = 1'b1;
					end
				end
			end
			PHASE_Q2: begin
				if (op == OP_TOGGLE) begin
					next_data_byte = mem_rdata_i;
				end
				if (op == OP_BRANCH) begin
					// (RULE6) sample overflow flag
					next_taken = overflow_flag_i;
				end
			end
			PHASE_Q3: begin
				if (op == OP_TOGGLE) begin
					// (RULE1) single bit inverted
					next_mem_wdata = data_byte ^ (8'h01 << bit_sel);
					// (RULE11) write strobe in Q4
					next_mem_wr    = 1'b1;
				end
				// (RULE12) no write when untaken
				if (op == OP_BRANCH && taken) begin
					// (RULE7) incremented pc plus 2n
					next_pc      = PC_W'(fetch_pc_i + word_disp(operand));
					next_pc_load = 1'b1;
				end
			end
			PHASE_Q4: begin
				// (RULE10) taken branch adds one cycle
				next_nop_cycle = (op == OP_BRANCH) && taken;
			end
			default: begin
				next_op = OP_NONE;
			end
		endcase
	end

	// Register stage; every output is a flop
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op                <= OP_NONE;
			operand           <= 8'h00;
			bit_sel           <= 3'h0;
			data_byte         <= DATA_RESET;
			taken             <= 1'b0;
			mem_addr_o        <= ADDR_RESET;
			mem_rd_o          <= 1'b0;
			mem_wr_o          <= 1'b0;
			mem_wdata_o       <= DATA_RESET;
			pc_load_o         <= 1'b0;
			program_counter_o <= PC_RESET;
			nop_cycle_o       <= 1'b0;
			status_we_o       <= 1'b0;
			phase_o           <= PHASE_Q1;
		end else begin
			op                <= next_op;
			operand           <= next_operand;
			bit_sel           <= next_bit_sel;
			data_byte         <= next_data_byte;
			taken             <= next_taken;
			mem_addr_o        <= next_mem_addr;
			mem_rd_o          <= next_mem_rd;
			mem_wr_o          <= next_mem_wr;
			mem_wdata_o       <= next_mem_wdata;
			pc_load_o         <= next_pc_load;
			program_counter_o <= next_pc;
			nop_cycle_o       <= next_nop_cycle;
			// (RULE11) flags never written
			status_we_o       <= 1'b0;
			phase_o           <= next_phase_o;
		end
	end

endmodule : bit_toggle_and_overflow_branch

// *** pkg/bto_pkg.sv ***
package bto_pkg;

	// Widths of the buses around the core
	localparam int unsigned PC_W     = 21;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned BANK_W   = 4;
	localparam int unsigned INSTR_W  = 16;
	localparam int unsigned PHASE_W  = 2;

	// Phase codes within one instruction cycle
	localparam logic [PHASE_W-1:0] PHASE_Q1 = 2'h0;
	localparam logic [PHASE_W-1:0] PHASE_Q2 = 2'h1;
	localparam logic [PHASE_W-1:0] PHASE_Q3 = 2'h2;
	localparam logic [PHASE_W-1:0] PHASE_Q4 = 2'h3;

	// Opcode fields
	localparam logic [3:0] OPC_TOGGLE_HI = 4'h7;   // instr[15:12]
	localparam logic [7:0] OPC_BRANCH_HI = 8'he4;  // instr[15:8]
	localparam int unsigned TOGGLE_BIT_MSB = 11;
	localparam int unsigned TOGGLE_BIT_LSB = 9;
	localparam int unsigned ACCESS_SEL_POS = 8;
	localparam int unsigned OPERAND_MSB    = 7;

	// Access bank layout
	localparam logic [7:0]        INDEXED_LIMIT   = 8'h5f;
	localparam logic [7:0]        ACCESS_SPLIT    = 8'h60;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

	// Reset values
	localparam logic [PC_W-1:0]   PC_RESET   = 21'h000000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// Operation held for the current instruction cycle
	typedef enum logic [1:0] {
		OP_NONE,
		OP_TOGGLE,
		OP_BRANCH,
		OP_FLUSH
	} op_t;

endpackage : bto_pkg

// *** pkg/phase_if.sv ***
`timescale 1ns/1ns
interface phase_if;
	import bto_pkg::*;

	logic [PHASE_W-1:0] phase;
	logic               cycle_end;

	modport source (output phase, output cycle_end);
	modport sink   (input phase, input cycle_end);

endinterface : phase_if

// *** hw/phase_sequencer.sv ***
`timescale 1ns/1ns
module phase_sequencer
	import bto_pkg::*;
(
	input  wire logic  clk_sys_i,
	input  wire logic  rst_n_i,
	phase_if.source    ph
);

	logic [PHASE_W-1:0] phase;
	logic [PHASE_W-1:0] next_phase;

	// Free-running Q1..Q4 count, wraps after the fourth phase
	always_comb begin
		next_phase = phase + 2'h1;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= PHASE_Q1;
		end else begin
			phase <= next_phase;
		end
	end

	// Phase and end-of-cycle mark for the execution logic
	assign ph.phase     = phase;
	assign ph.cycle_end = (phase == PHASE_Q4);

endmodule : phase_sequencer

// *** tb/bit_toggle_and_overflow_branch_assertions.sv ***
`timescale 1ns/1ns
module bto_checker
	import bto_pkg::*;
(
	input wire logic               clk_sys_i,
	input wire logic               rst_n_i,
	input wire logic [INSTR_W-1:0] instr_i,
	input wire logic               overflow_flag_i,
	input wire logic [PC_W-1:0]    fetch_pc_i,
	input wire logic [DATA_W-1:0]  mem_rdata_i,
	input wire logic [ADDR_W-1:0]  mem_addr_o,
	input wire logic               mem_rd_o,
	input wire logic               mem_wr_o,
	input wire logic [DATA_W-1:0]  mem_wdata_o,
	input wire logic               pc_load_o,
	input wire logic [PC_W-1:0]    program_counter_o,
	input wire logic               nop_cycle_o,
	input wire logic               status_we_o,
	input wire logic [PHASE_W-1:0] phase_o
);
	logic [7:0]      op_hi;
	logic [PC_W-1:0] disp;
	// Opcode and doubled signed offset, kept as plain signals so $past can see them
	assign op_hi = instr_i[15:8];
	assign disp = {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	AST_RD_Q2: assert property (mem_rd_o |-> phase_o == PHASE_Q2)
		else $error("read strobe outside Q2");
	AST_WR_Q4: assert property (mem_rd_o |-> ##2 mem_wr_o && phase_o == PHASE_Q4)
		else $error("write does not follow read by two clocks");
	AST_ONE_BIT: assert property (
		mem_rd_o |-> ##2 $onehot(mem_wdata_o ^ $past(mem_rdata_i, 2)))
		else $error("write data differs from read data in other than one bit");
	AST_SAME_BYTE: assert property (mem_rd_o |=> $stable(mem_addr_o) [*2])
		else $error("address moved between read and write");
	AST_NO_FLAGS: assert property (!status_we_o)
		else $error("status write strobe raised");
	AST_LOAD_CAUSE: assert property (
		pc_load_o |-> phase_o == PHASE_Q4 && $past(overflow_flag_i, 2)
			&& $past(op_hi, 3) == OPC_BRANCH_HI)
		else $error("counter load without taken overflow branch");
	AST_TARGET: assert property (
		pc_load_o |-> program_counter_o == $past(fetch_pc_i) + $past(disp, 3))
		else $error("branch target wrong");
	AST_NOP_FOUR: assert property (pc_load_o |=> nop_cycle_o [*4] ##1 !nop_cycle_o)
		else $error("no-operation cycle not four clocks");
	AST_NOP_CAUSE: assert property ($rose(nop_cycle_o) |-> $past(pc_load_o))
		else $error("no-operation cycle without taken branch");
	// The flushed decode would show its strobes while the no-operation level stands
	AST_FLUSH_IGNORED: assert property (nop_cycle_o |-> !mem_rd_o && !pc_load_o)
		else $error("instruction in flush cycle executed");
endmodule : bto_checker

bind bit_toggle_and_overflow_branch bto_checker u_chk (.clk_sys_i, .rst_n_i, .instr_i,
	.overflow_flag_i, .fetch_pc_i, .mem_rdata_i, .mem_addr_o, .mem_rd_o, .mem_wr_o,
	.mem_wdata_o, .pc_load_o, .program_counter_o, .nop_cycle_o, .status_we_o, .phase_o);

// *** tb/data_mem_model.sv ***
`timescale 1ns/1ns
module data_mem_model
	import bto_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic [ADDR_W-1:0] mem_addr_i,
	input  wire logic              mem_rd_i,
	input  wire logic              mem_wr_i,
	input  wire logic [DATA_W-1:0] mem_wdata_i,
	output logic      [DATA_W-1:0] mem_rdata_o
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] junk = 8'h3c;
	initial foreach (mem[i]) mem[i] = 8'(i * 7);
	// Unselected bus shows a changing pattern, so a late sample cannot pass by luck
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : junk;
	always @(posedge clk_sys_i) begin
		junk <= ~junk + 8'h01;
		if (mem_wr_i)
			mem[mem_addr_i] <= mem_wdata_i;
	end
endmodule : data_mem_model

// *** tb/test_bit_toggle_and_overflow_branch.sv ***
`timescale 1ns/1ns
module test_bit_toggle_and_overflow_branch;
	import bto_pkg::*;
	logic clk_sys_i, rst_n_i, instr_valid_i, overflow_flag_i, ext_set_en_i;
	logic [INSTR_W-1:0] instr_i;
	logic [BANK_W-1:0]  data_bank_selector_i;
	logic [ADDR_W-1:0]  index_base_i, mem_addr_o;
	logic [PC_W-1:0]    fetch_pc_i, program_counter_o;
	logic [DATA_W-1:0]  mem_rdata_i, mem_wdata_o;
	logic mem_rd_o, mem_wr_o, pc_load_o, nop_cycle_o, status_we_o;
	logic [PHASE_W-1:0] phase_o;
	logic [19:0] mq[$];
	logic [20:0] pq[$];
	logic [7:0]  sh [4096];
	logic [7:0]  ft [4] = '{8'h5f, 8'h60, 8'h00, 8'hff};
	logic [15:0] r = 16'h0022;
	int fail_count = 0;
	int n_checks = 0;

	bit_toggle_and_overflow_branch u_dut (.clk_sys_i, .rst_n_i, .instr_i, .instr_valid_i,
		.overflow_flag_i, .data_bank_selector_i, .ext_set_en_i, .index_base_i, .fetch_pc_i,
		.mem_rdata_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .pc_load_o,
		.program_counter_o, .nop_cycle_o, .status_we_o, .phase_o);
	data_mem_model u_mem (.clk_sys_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
		.mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Expected data address from the access bit, bank and indexed window
	function automatic logic [11:0] ea(input logic [15:0] ins);
		if (ins[8])
			return {data_bank_selector_i, ins[7:0]};
		if (ext_set_en_i && ins[7:0] <= 8'h5f)
			return index_base_i + 12'(ins[7:0]);
		return {ins[7:0] >= 8'h60 ? 4'hf : 4'h0, ins[7:0]};
	endfunction : ea

	task automatic chk_mem(input logic [19:0] e, input logic [19:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error mem addr/data expected %h seen %h", e, g);
		end
	endtask : chk_mem

	task automatic chk_pc(input logic [20:0] e, input logic [20:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error program_counter expected %h seen %h", e, g);
		end
	endtask : chk_pc

	task automatic final_report;
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// One instruction slot of four clocks; ign marks a slot the design must drop
	task automatic issue(input logic [15:0] ins, input logic v, input logic ov, input logic ign);
		logic [11:0] a;
		logic [7:0]  d;
		instr_i = ins;
		instr_valid_i = v;
		overflow_flag_i = ov;
		a = ea(ins);
		d = sh[a] ^ (8'h01 << ins[11:9]);
		if (v && !ign && ins[15:8] == 8'he4 && ov)
			pq.push_back(fetch_pc_i + {{12{ins[7]}}, ins[7:0], 1'b0});
		if (v && !ign && ins[15:12] == 4'h7) begin
			sh[a] = d;
			mq.push_back({a, d});
		end
		repeat (4) @(negedge clk_sys_i);
	endtask : issue

	// Outputs are settled at the falling edge; an empty queue expects nothing
	always @(negedge clk_sys_i) begin
		if (mem_wr_o === 1'b1)
			chk_mem(mq.size() ? mq.pop_front() : 20'hx, {mem_addr_o, mem_wdata_o});
		if (pc_load_o === 1'b1)
			chk_pc(pq.size() ? pq.pop_front() : 21'hx, program_counter_o);
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		#200000;
		fail_count++;
		final_report();
	end

	initial begin
		foreach (sh[i]) sh[i] = 8'(i * 7);
		{rst_n_i, instr_i, instr_valid_i, overflow_flag_i, ext_set_en_i} = '0;
		{data_bank_selector_i, index_base_i, fetch_pc_i} = '0;
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		for (int i = 0; i < 40; i++) begin
			r = lfsr(r);
			data_bank_selector_i = r[3:0];
			ext_set_en_i = i < 8 ? i[2] : r[4];
			index_base_i = r[15:4];
			issue({4'h7, 3'(i), i < 8 ? 1'b0 : r[8], i < 8 ? ft[i % 4] : r[7:0]},
				i < 8 || r[9] || r[10], 1'b0, 1'b0);
		end
		// Back-to-back toggles of one byte
		issue(16'h7b40, 1'b1, 1'b0, 1'b0);
		issue(16'h7340, 1'b1, 1'b0, 1'b0);
		for (int k = 0; k < 16; k++) begin
			r = lfsr(r);
			fetch_pc_i = {r[4:0], r};
			issue({8'he4, k < 8 ? ft[k % 4] ^ 8'h20 : r[7:0]}, 1'b1, k[2], 1'b0);
			// The slot right after a taken branch is the flush cycle
			if (k[2]) begin
				issue(16'h7e01, 1'b1, 1'b0, 1'b1);
				issue(16'h0000, 1'b0, 1'b0, 1'b0);
			end
		end
		repeat (8) @(negedge clk_sys_i);
		chk_pc(21'h0, 21'(mq.size() + pq.size()));
		final_report();
	end
endmodule : test_bit_toggle_and_overflow_branch
